// ### tmcf_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Test mode only while enabled and the chosen trigger is logic 1.
// - Fixed On trigger: test mode starts when enable goes Disabled to Enabled.
// - Operand trigger: test mode starts when that operand becomes 1.
// - Indicator flashes for as long as test mode is active.
// - Only contact reporting and driving change; other paths untouched.
// - Each contact input and output has its own force setting.
// - Output force: open, closed, frozen or normal.
// - Input forced Disabled keeps reporting its terminal state.
// - Input forced Open reports 0 during test mode.
// - Input forced Closed reports 1 during test mode.
// - All input forces Disabled: all inputs report normally.
// - Freeze output holds its pre-test state throughout test mode.
// - Energize stays closed, De-energize stays open during test mode.
module tmcf_top #(
  parameter int FLASH_HALF_CYC = tmcf_pkg::FLASH_HALF_CYC
) (
  input wire logic clk, // Clock, 250 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic test_enable, // Test-mode function enabled
  input wire logic [tmcf_pkg::SEL_W-1:0] trig_sel, // Trigger select
  input wire logic [tmcf_pkg::NUM_OPERAND-1:0] operands, // Logic operands
  input wire logic [2*tmcf_pkg::NUM_IN-1:0] in_force, // Input forces
  input wire logic [2*tmcf_pkg::NUM_OUT-1:0] out_force, // Output forces
  input wire logic [tmcf_pkg::NUM_IN-1:0] in_pins, // Terminal inputs
  input wire logic [tmcf_pkg::NUM_OUT-1:0] out_ctrl, // Output operands
  output logic [tmcf_pkg::NUM_IN-1:0] in_report, // Reported inputs
  output logic [tmcf_pkg::NUM_OUT-1:0] out_drive, // Contact drive
  output logic test_active, // Test mode active
  output logic test_led // Flashing indicator
);

  logic [tmcf_pkg::NUM_IN-1:0] pins_s;
  logic en_prev_q;
  logic trig_prev_q;
  logic test_q;
  logic test_d;
  logic trig_now;
  logic [tmcf_pkg::NUM_OUT-1:0] frozen_q;

  // ------------------------------------------------------------
  // Terminal synchroniser
  // ------------------------------------------------------------
  tmcf_sync #(.W(tmcf_pkg::NUM_IN)) tmcf_sync_i (
    .clk(clk),
    .rstn(rstn),
    .d(in_pins),
    .q(pins_s)
  );

  function automatic logic sel_trigger(
    input logic [tmcf_pkg::SEL_W-1:0] sel,
    input logic [tmcf_pkg::NUM_OPERAND-1:0] ops
  );
    if (sel == tmcf_pkg::SEL_ON) begin
      return 1'b1;
    end else if (int'(sel) < tmcf_pkg::NUM_OPERAND) begin
      return ops[sel[2:0]];
    end
    return 1'b0;
  endfunction : sel_trigger

  assign trig_now = sel_trigger(trig_sel, operands);

  // ------------------------------------------------------------
  // Test-mode entry and exit
  // ------------------------------------------------------------
  always_comb begin
    test_d = test_q;
    if (!test_enable || !trig_now) begin
      test_d = 1'b0;
    end else if (trig_sel == tmcf_pkg::SEL_ON) begin
      if (!en_prev_q) begin
        test_d = 1'b1;
      end
    end else if (!trig_prev_q) begin
      test_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      en_prev_q <= test_enable;
      trig_prev_q <= trig_now;
      test_q <= test_d;
    end
  end

  assign test_active = test_q;

  // ------------------------------------------------------------
  // Indicator
  // ------------------------------------------------------------
  // Next state, so the indicator goes dark on the edge test mode ends
  tmcf_flash #(.HALF_CYC(FLASH_HALF_CYC)) tmcf_flash_i (
    .clk(clk),
    .rstn(rstn),
    .run(test_d),
    .led(test_led)
  );

  // ------------------------------------------------------------
  // Freeze capture: track until test mode starts
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frozen_q <= '0;
    end else if (!test_q) begin
      frozen_q <= out_drive;
    end
  end

  // ------------------------------------------------------------
  // Contact forcing, per channel
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_report <= '0;
    end else begin
      for (int i = 0; i < tmcf_pkg::NUM_IN; i++) begin
        in_report[i] <= pins_s[i];
        if (test_d) begin
          unique case (tmcf_pkg::tmcf_in_force_t'(in_force[2*i +: 2]))
            tmcf_pkg::TMCF_IN_OPEN: in_report[i] <= 1'b0;
            tmcf_pkg::TMCF_IN_CLOSED: in_report[i] <= 1'b1;
            default: in_report[i] <= pins_s[i];
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_drive <= '0;
    end else begin
      for (int j = 0; j < tmcf_pkg::NUM_OUT; j++) begin
        out_drive[j] <= out_ctrl[j];
        if (test_d) begin
          unique case (tmcf_pkg::tmcf_out_force_t'(out_force[2*j +: 2]))
            tmcf_pkg::TMCF_OUT_DEENERGIZE: out_drive[j] <= 1'b0;
            tmcf_pkg::TMCF_OUT_ENERGIZE: out_drive[j] <= 1'b1;
            tmcf_pkg::TMCF_OUT_FREEZE: begin
              out_drive[j] <= test_q ? frozen_q[j] : out_drive[j];
            end
            tmcf_pkg::TMCF_OUT_DISABLED: out_drive[j] <= out_ctrl[j];
          endcase
        end
      end
    end
  end

endmodule : tmcf_top

// ### tmcf_pkg.sv
package tmcf_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NUM_IN = 16;
  localparam int NUM_OUT = 16;
  localparam int NUM_OPERAND = 8;
  localparam int SEL_W = 4;

  // ------------------------------------------------------------
  // Trigger selection
  // ------------------------------------------------------------
  // Code SEL_ON means fixed On; codes below NUM_OPERAND pick an operand
  localparam logic [SEL_W-1:0] SEL_ON = 4'hf;

  // ------------------------------------------------------------
  // Force codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TMCF_IN_DISABLED = 2'h0,
    TMCF_IN_OPEN = 2'h1,
    TMCF_IN_CLOSED = 2'h2
  } tmcf_in_force_t;

  typedef enum logic [1:0] {
    TMCF_OUT_DISABLED = 2'h0,
    TMCF_OUT_DEENERGIZE = 2'h1,
    TMCF_OUT_ENERGIZE = 2'h2,
    TMCF_OUT_FREEZE = 2'h3
  } tmcf_out_force_t;

  // ------------------------------------------------------------
  // Indicator timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int FLASH_CNT_W = 26;
  localparam logic RST_FLASH = 1'b0;

endpackage : tmcf_pkg

// ### tmcf_sync.sv
`timescale 1ns/1ps
module tmcf_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : tmcf_sync

// ### tmcf_flash.sv
`timescale 1ns/1ps
module tmcf_flash #(
  parameter int HALF_CYC = tmcf_pkg::FLASH_HALF_CYC
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, active low
  input wire logic run, // Flash while high
  output logic led // Indicator drive
);

  logic [tmcf_pkg::FLASH_CNT_W-1:0] cnt_q;

  // ------------------------------------------------------------
  // Half-period divider
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      led <= tmcf_pkg::RST_FLASH;
    end else if (!run) begin
      cnt_q <= '0;
      led <= 1'b0;
    end else if (cnt_q == tmcf_pkg::FLASH_CNT_W'(HALF_CYC - 1)) begin
      cnt_q <= '0;
      led <= ~led;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : tmcf_flash

// ### tmcf_chk_sva.sv
`timescale 1ns/1ps
module tmcf_chk (
  input logic clk, // Clock
  input logic rstn, // Async reset, active low
  input logic test_enable, // Mode enable
  input logic [31:0] in_force, // Input forces
  input logic [31:0] out_force, // Output forces
  input logic [15:0] out_ctrl, // Output operands
  input logic [15:0] in_report, // Reported inputs
  input logic [15:0] out_drive, // Contact drive
  input logic test_active, // Mode active
  input logic test_led // Indicator
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  entry_cause_a: assert property ($rose(test_active) |-> $past(test_enable))
    else $error("test mode entered while disabled");
  exit_drop_a: assert property (test_active && !test_enable |=> !test_active)
    else $error("test mode kept after disable");
  led_idle_a: assert property (!test_active |-> !test_led)
    else $error("indicator lit outside test mode");
  in_open_a: assert property (test_active && $past(in_force[1:0]) == 2'h1
    |-> !in_report[0]) else $error("open input not reported low");
  in_closed_a: assert property (test_active && $past(in_force[3:2]) == 2'h2
    |-> in_report[1]) else $error("closed input not reported high");
  out_energ_a: assert property (test_active && $past(out_force[5:4]) == 2'h2
    |-> out_drive[2]) else $error("energized output not closed");
  out_deen_a: assert property (test_active && $past(out_force[7:6]) == 2'h1
    |-> !out_drive[3]) else $error("de-energized output not open");
  out_frz_a: assert property (test_active && $past(test_active)
    && $past(out_force[1:0]) == 2'h3 |-> $stable(out_drive[0]))
    else $error("frozen output moved");
  out_norm_a: assert property (!test_active && $past(rstn)
    |-> out_drive == $past(out_ctrl)) else $error("output not normal");
endmodule : tmcf_chk
bind tmcf_top tmcf_chk tmcf_chk_i (.*);

// ### tmcf_field.sv
`timescale 1ns/1ps
module tmcf_field (
  input wire logic clk, // Clock
  input wire logic [15:0] level, // Wanted terminal voltages
  output logic [15:0] pins // Sensed terminals
);
  // Field wiring settles one cycle late
  always_ff @(posedge clk) pins <= level;
endmodule : tmcf_field

// ### test_tmcf_top.sv
`timescale 1ns/1ps
module test_tmcf_top;
  logic clk = 0, rstn = 0, test_enable = 0, test_active, test_led;
  logic [3:0] trig_sel = 4'h0;
  logic [7:0] operands = 8'h00;
  logic [31:0] in_force = 32'h0, out_force = 32'h0;
  logic [15:0] level = 16'h0, out_ctrl = 16'h0;
  logic [15:0] in_pins, in_report, out_drive;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #2 clk = ~clk;
  tmcf_field tmcf_field_i (.clk(clk), .level(level), .pins(in_pins));
  tmcf_top #(.FLASH_HALF_CYC(4)) tmcf_top_i (.*);
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic summarize;
    $display("counts: %0d checks, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic t_operand;
    int n;
    n = 0;
    in_force = 32'h0000_0009;
    out_force = 32'h0000_0063;
    level = 16'h0005;
    out_ctrl = 16'h0009;
    test_enable = 1;
    wt(6);
    chk(16'h0005, in_report);
    chk(16'h0009, out_drive);
    operands[0] = 1;
    wt(1);
    chk(16'h0001, {15'h0, test_active});
    out_ctrl = 16'h0002;
    level = 16'h0001;
    wt(6);
    chk(16'h0002, in_report);
    chk(16'h0007, out_drive);
    repeat (12) begin
      wt(1);
      n += test_led;
    end
    chk(16'h0001, {15'h0, n != 0});
    operands[0] = 0;
    wt(1);
    chk(16'h0000, {14'h0, test_active, test_led});
    wt(4);
    chk(16'h0001, in_report);
    chk(16'h0002, out_drive);
    $display("test operand done");
  endtask : t_operand
  task automatic t_fixed;
    trig_sel = 4'hf;
    in_force = 32'h0;
    wt(3);
    chk(16'h0000, {15'h0, test_active});
    test_enable = 0;
    wt(2);
    test_enable = 1;
    wt(1);
    chk(16'h0001, {15'h0, test_active});
    chk(16'h0001, in_report);
    test_enable = 0;
    wt(1);
    chk(16'h0000, {15'h0, test_active});
    trig_sel = 4'h0;
    operands = 8'h01;
    wt(2);
    test_enable = 1;
    wt(3);
    chk(16'h0000, {15'h0, test_active});
    $display("test fixed done");
  endtask : t_fixed
  initial begin
    wt(4);
    rstn = 1;
    wt(2);
    t_operand;
    t_fixed;
    summarize;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      summarize;
    end
  end
endmodule : test_tmcf_top
